//--- smx_pkg.sv
// constants for the slave controller instruction executor: opcodes, layout, timing
// assumes one 40 MHz clock and program/data sources on the same clock
// Behaviour
// - With external fetch enabled, port data is valid on the port bus at the cycle strobe's rising edge.
// - With external fetch enabled, the program counter is placed on the port bus at the strobe's falling edge.
// - page_lookup loads A from program memory in the current page at address A, one byte, two cycles.
// - fixed_page_lookup loads A from program memory page 3 at address A, one byte, two cycles.
// - nibble_exchange swaps A's low nibble with the low nibble of data memory at @working_register.
// - full_exchange indirect swaps A with the data memory byte at @working_register in one cycle.
// - full_exchange direct swaps A with a working_register of the active bank in one cycle.
// - The indirect load copies the data memory byte at @working_register into A in one cycle.
// - The immediate indirect store writes its second byte to data memory at @working_register, two cycles.
// - The status update copies A bits 4-7 into host_status_register bits 4-7, lower bits untouched.
// - rotate_left_with_carry shifts A left one place, old carry to bit 0, old bit 7 to carry.
// - A one-cycle instruction sets the timer_overflow_irq enable.
package smx_pkg;
    localparam int PC_W = 12;
    localparam int CYCLE_CLKS = 15;          // clocks per machine cycle
    localparam logic [3:0] FIXED_PAGE = 4'h3;
    localparam logic [4:0] BANK1_BASE = 5'h18;
    localparam logic [PC_W-1:0] PC_RESET = 12'h000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // host status layout
    localparam int ST_OBF = 0;
    localparam int ST_IBF = 1;
    // opcodes
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_OUT_BUF = 8'h02;
    localparam logic [7:0] OP_TF_BRANCH = 8'h16;
    localparam logic [7:0] OP_XCH_IND = 8'h20;   // low bit picks pointer
    localparam logic [7:0] OP_IN_BUF = 8'h22;
    localparam logic [7:0] OP_EN_TIRQ = 8'h25;
    localparam logic [7:0] OP_XCH_REG = 8'h28;   // low three bits pick register
    localparam logic [7:0] OP_NIBBLE_EXCHANGE_IND = 8'h30;
    localparam logic [7:0] OP_MOV_STATUS = 8'h90;
    localparam logic [7:0] OP_PAGE_LOOKUP = 8'hA3;
    localparam logic [7:0] OP_STORE_IMM = 8'hB0;
    localparam logic [7:0] OP_FIXED_LOOKUP = 8'hE3;
    localparam logic [7:0] OP_LOAD_IND = 8'hF0;
    localparam logic [7:0] OP_RLC = 8'hF7;
    // second-cycle kinds
    typedef enum logic [1:0] {
        SMX_ST_ONE = 2'b00,
        SMX_ST_TWO = 2'b01
    } smx_state_e;
endpackage : smx_pkg

//--- smx_strobe.sv
// machine-cycle divider and cycle strobe generator
// assumes a free-running clock; all outputs registered
module smx_strobe #(
    parameter int CLKS = smx_pkg::CYCLE_CLKS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // timing outputs
    output logic cycle_en,
    output logic sync,
    output logic sync_rise,
    output logic sync_fall
);
    logic [7:0] count;
    logic next_sync;

    // count clocks within one machine cycle
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            count <= 8'h00;
        else if (count == 8'(CLKS - 1))
            count <= 8'h00;
        else
            count <= count + 8'h01;
    end

    assign next_sync = (count < 8'(CLKS / 2));

    // strobe high in the first half, pulses mark its edges
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync <= 1'b0;
            sync_rise <= 1'b0;
            sync_fall <= 1'b0;
            cycle_en <= 1'b0;
        end
        else
        begin
            sync <= next_sync;
            sync_rise <= next_sync && !sync;
            sync_fall <= !next_sync && sync;
            cycle_en <= (count == 8'(CLKS - 1));
        end
    end
endmodule : smx_strobe

//--- smx_core.sv
// instruction executor: fetch, decode and execute of the data move subset
// assumes program memory answers prog_addr within one machine cycle
module smx_core #(
    parameter int DMEM_WORDS = 64
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // program memory
    output logic [smx_pkg::PC_W-1:0] prog_addr,
    input wire logic [7:0] prog_data,
    // external access strobe and port bus
    input wire logic external_fetch_pin,
    input wire logic [7:0] port_data,
    output logic sync,
    output logic [smx_pkg::PC_W-1:0] port_bus,
    // host side of the data buffer
    input wire logic host_wr,
    input wire logic [7:0] host_wdata,
    input wire logic host_rd,
    output logic [7:0] host_data_buffer,
    output logic [7:0] host_status_register,
    output logic input_full_flag,
    output logic output_full_flag,
    // timer and control
    input wire logic timer_overflow,
    input wire logic reg_bank_sel,
    output logic timer_overflow_irq,
    output logic [7:0] acc,
    output logic carry
);
    localparam int DA_W = $clog2(DMEM_WORDS);
    default clocking smx_cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    logic cycle_en, sync_rise, sync_fall;
    logic ext_meta, ext_sync;
    smx_pkg::smx_state_e state;
    logic [7:0] op, in_buf, status_hi, timer_flag_q;
    logic [smx_pkg::PC_W-1:0] pc, pc_inc;
    logic [7:0] dmem [DMEM_WORDS];
    logic [DA_W-1:0] reg_addr, ind_addr;
    logic [7:0] ind_ptr, ind_val, reg_val;
    logic timer_flag, do_in_buf, do_out_buf, is_jtf, at_one;

    smx_strobe #(.CLKS(smx_pkg::CYCLE_CLKS)) u_strobe (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .cycle_en(cycle_en),
        .sync(sync),
        .sync_rise(sync_rise),
        .sync_fall(sync_fall)
    );

    // external fetch pin synchroniser
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
        end
        else
        begin
            ext_meta <= external_fetch_pin;
            ext_sync <= ext_meta;
        end
    end

    // operand addressing through the active bank
    assign pc_inc = pc + 12'h001;
    assign reg_addr = DA_W'({reg_bank_sel ? smx_pkg::BANK1_BASE : 5'h00} + {2'b00, prog_data[2:0]});
    assign ind_ptr = dmem[DA_W'({reg_bank_sel ? smx_pkg::BANK1_BASE : 5'h00}
        + {4'h0, (state == smx_pkg::SMX_ST_TWO ? op[0] : prog_data[0])})];
    assign ind_addr = DA_W'(ind_ptr);
    assign ind_val = dmem[ind_addr];
    assign reg_val = dmem[reg_addr];
    assign do_in_buf = cycle_en && state == smx_pkg::SMX_ST_ONE && prog_data == smx_pkg::OP_IN_BUF;
    assign do_out_buf = cycle_en && state == smx_pkg::SMX_ST_ONE && prog_data == smx_pkg::OP_OUT_BUF;
    assign is_jtf = cycle_en && state == smx_pkg::SMX_ST_ONE && prog_data == smx_pkg::OP_TF_BRANCH;
    assign at_one = cycle_en && state == smx_pkg::SMX_ST_ONE;

    // sequencer: program counter, fetch address, opcode and state
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= smx_pkg::SMX_ST_ONE;
            pc <= smx_pkg::PC_RESET;
            prog_addr <= smx_pkg::PC_RESET;
            op <= smx_pkg::OP_NOP;
        end
        else if (cycle_en)
        begin
            unique case (state)
                smx_pkg::SMX_ST_ONE:
                begin
                    pc <= pc_inc;
                    prog_addr <= pc_inc;
                    if (prog_data == smx_pkg::OP_PAGE_LOOKUP)
                    begin
                        prog_addr <= {pc_inc[11:8], acc};
                        op <= prog_data;
                        state <= smx_pkg::SMX_ST_TWO;
                    end
                    else if (prog_data == smx_pkg::OP_FIXED_LOOKUP)
                    begin
                        prog_addr <= {smx_pkg::FIXED_PAGE, acc};
                        op <= prog_data;
                        state <= smx_pkg::SMX_ST_TWO;
                    end
                    else if ({prog_data[7:1], 1'b0} == smx_pkg::OP_STORE_IMM
                        || prog_data == smx_pkg::OP_TF_BRANCH)
                    begin
                        op <= prog_data;
                        state <= smx_pkg::SMX_ST_TWO;
                    end
                end
                smx_pkg::SMX_ST_TWO:
                begin
                    state <= smx_pkg::SMX_ST_ONE;
                    if (op == smx_pkg::OP_TF_BRANCH && timer_flag_q[0])
                    begin
                        pc <= {pc[11:8], prog_data};
                        prog_addr <= {pc[11:8], prog_data};
                    end
                    else if (op == smx_pkg::OP_PAGE_LOOKUP || op == smx_pkg::OP_FIXED_LOOKUP)
                        prog_addr <= pc;
                    else
                    begin
                        pc <= pc_inc;
                        prog_addr <= pc_inc;
                    end
                end
                default:
                    state <= smx_pkg::SMX_ST_ONE;
            endcase
        end
    end

    // accumulator and carry
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            acc <= smx_pkg::BYTE_RESET;
            carry <= 1'b0;
        end
        else if (cycle_en && state == smx_pkg::SMX_ST_TWO)
        begin
            if (op == smx_pkg::OP_PAGE_LOOKUP || op == smx_pkg::OP_FIXED_LOOKUP)
                acc <= prog_data;
        end
        else if (cycle_en)
        begin
            if (prog_data == smx_pkg::OP_RLC)
            begin
                acc <= {acc[6:0], carry};
                carry <= acc[7];
            end
            else if ({prog_data[7:1], 1'b0} == smx_pkg::OP_NIBBLE_EXCHANGE_IND)
                acc <= {acc[7:4], ind_val[3:0]};
            else if ({prog_data[7:1], 1'b0} == smx_pkg::OP_XCH_IND
                || {prog_data[7:1], 1'b0} == smx_pkg::OP_LOAD_IND)
                acc <= ind_val;
            else if ({prog_data[7:3], 3'b000} == smx_pkg::OP_XCH_REG)
                acc <= reg_val;
            else if (prog_data == smx_pkg::OP_IN_BUF)
                acc <= in_buf;
        end
    end

    // data memory writes, cleared at reset so pointers start at zero
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            foreach (dmem[i])
                dmem[i] <= smx_pkg::BYTE_RESET;
        else if (cycle_en && state == smx_pkg::SMX_ST_ONE)
        begin
            if ({prog_data[7:1], 1'b0} == smx_pkg::OP_NIBBLE_EXCHANGE_IND)
                dmem[ind_addr] <= {ind_val[7:4], acc[3:0]};
            else if ({prog_data[7:1], 1'b0} == smx_pkg::OP_XCH_IND)
                dmem[ind_addr] <= acc;
            else if ({prog_data[7:3], 3'b000} == smx_pkg::OP_XCH_REG)
                dmem[reg_addr] <= acc;
        end
        else if (cycle_en && op[7:1] == smx_pkg::OP_STORE_IMM[7:1])
            dmem[ind_addr] <= prog_data;
    end

    // host buffer flags, a setting event wins over a clear
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            in_buf <= smx_pkg::BYTE_RESET;
            host_data_buffer <= smx_pkg::BYTE_RESET;
            input_full_flag <= 1'b0;
            output_full_flag <= 1'b0;
        end
        else
        begin
            if (host_wr)
                in_buf <= host_wdata;
            if (host_wr)
                input_full_flag <= 1'b1;
            else if (do_in_buf)
                input_full_flag <= 1'b0;
            if (do_out_buf)
            begin
                host_data_buffer <= acc;
                output_full_flag <= 1'b1;
            end
            else if (host_rd)
                output_full_flag <= 1'b0;
        end
    end

    // status nibble, timer flag and interrupt enable
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            status_hi <= smx_pkg::BYTE_RESET;
            timer_flag_q <= smx_pkg::BYTE_RESET;
            timer_overflow_irq <= 1'b0;
        end
        else
        begin
            if (cycle_en && state == smx_pkg::SMX_ST_ONE && prog_data == smx_pkg::OP_MOV_STATUS)
                status_hi <= {acc[7:4], 4'h0};
            if (cycle_en && state == smx_pkg::SMX_ST_ONE && prog_data == smx_pkg::OP_EN_TIRQ)
                timer_overflow_irq <= 1'b1;
            if (timer_overflow)
                timer_flag_q <= 8'h01;
            else if (is_jtf)
                timer_flag_q <= {7'h00, timer_flag_q[0]};
            else if (cycle_en && state == smx_pkg::SMX_ST_TWO && op == smx_pkg::OP_TF_BRANCH)
                timer_flag_q <= 8'h00;
        end
    end
    assign timer_flag = timer_flag_q[0];
    assign host_status_register = {status_hi[7:4], 2'b00, input_full_flag, output_full_flag};

    // port bus during external access
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
            port_bus <= smx_pkg::PC_RESET;
        else if (sync_rise || !ext_sync)
            port_bus <= {4'h0, port_data};
        else if (sync_fall)
            port_bus <= pc;
    end

    // checks
    a_rise_port_data: assert property (sync_rise && ext_sync
        |=> port_bus == {4'h0, $past(port_data)}) else $error("no port data at rise");
    a_fall_pc: assert property (sync_fall && ext_sync
        |=> port_bus == $past(pc)) else $error("pc not shown at strobe fall");
    a_lookup_two: assert property (at_one && prog_data == smx_pkg::OP_PAGE_LOOKUP |=>
        state == smx_pkg::SMX_ST_TWO && prog_addr[7:0] == $past(acc)) else $error("lookup wrong");
    a_fixed_page: assert property (at_one && prog_data == smx_pkg::OP_FIXED_LOOKUP |=>
        prog_addr == {smx_pkg::FIXED_PAGE, $past(acc)}) else $error("fixed lookup wrong");
    a_rlc_result: assert property (at_one && prog_data == smx_pkg::OP_RLC |=>
        {carry, acc} == {$past(acc), $past(carry)}) else $error("rotate wrong");
    a_status_nib: assert property (at_one && prog_data == smx_pkg::OP_MOV_STATUS |=>
        host_status_register[7:4] == $past(acc[7:4])) else $error("status nibble not copied");
    a_tirq_enable: assert property (at_one && prog_data == smx_pkg::OP_EN_TIRQ |=>
        timer_overflow_irq) else $error("timer interrupt not enabled");
    a_obf_set: assert property (do_out_buf |=> output_full_flag
        && host_data_buffer == $past(acc)) else $error("output buffer not loaded");
    a_ibf_clear: assert property (do_in_buf && !host_wr
        |=> !input_full_flag) else $error("input full flag not cleared");
    a_jtf_clear: assert property (cycle_en && state == smx_pkg::SMX_ST_TWO
        && op == smx_pkg::OP_TF_BRANCH && !timer_overflow |=> !timer_flag)
        else $error("timer flag survived branch");
    c_lookup: cover property (cycle_en && state == smx_pkg::SMX_ST_TWO
        && op == smx_pkg::OP_PAGE_LOOKUP);
    c_jtf_taken: cover property (is_jtf && timer_flag);
    c_ext_fetch: cover property (sync_fall && ext_sync);
endmodule : smx_core

//--- smx_prog_mem.sv
// program memory model standing behind the executor's fetch port
// assumes one clock; the bench places the image before reset ends
module smx_prog_mem #(
    parameter int DEPTH = 4096
) (
    // clock
    input wire logic mclk,
    // fetch port
    input wire logic [smx_pkg::PC_W-1:0] prog_addr,
    output logic [7:0] prog_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:DEPTH-1];
    // blank image, so unused places read as a no-operation
    initial
    begin
        foreach (mem[i])
        begin
            mem[i] = 8'h00;
        end
    end
    // bench places one program byte
    task automatic put(input logic [smx_pkg::PC_W-1:0] addr, input logic [7:0] data);
        mem[addr] = data;
    endtask : put
    // answer one clock after the address, well inside the machine cycle
    always_ff @(posedge mclk)
    begin
        prog_data <= mem[prog_addr];
    end
endmodule : smx_prog_mem

//--- tb_slave_mcu_instruction_exec.sv
// self-checking bench: runs a small program and checks results at mid machine cycle
// assumes 15-clock machine cycles, first opcode executed at the 16th clock after reset release
module tb_slave_mcu_instruction_exec;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, sys_rst, external_fetch_pin, host_wr, host_rd, timer_overflow, reg_bank_sel;
    logic sync, input_full_flag, output_full_flag, timer_overflow_irq, carry;
    logic [7:0] port_data, host_wdata, prog_data, host_data_buffer, host_status_register, acc;
    logic [smx_pkg::PC_W-1:0] prog_addr, port_bus;
    int n_fail, checks, edges;
    // program image, address in the upper bits and byte in the lower
    logic [19:0] image [0:21] = '{20'h0_0022, 20'h0_0190, 20'h0_0202, 20'h0_03F7,
        20'h0_04F7, 20'h0_05B0, 20'h0_063C, 20'h0_0728, 20'h0_0821, 20'h0_0931,
        20'h0_0AF1, 20'h0_0BA3, 20'h0_0CE3, 20'h0_0D25, 20'h0_0E16, 20'h0_0F20,
        20'h0_2016, 20'h0_2130, 20'h0_355A, 20'h3_5A77, 20'h0_2728, 20'h0_2828};

    smx_core #(.DMEM_WORDS(64)) dut (.mclk(mclk), .sys_rst(sys_rst), .prog_addr(prog_addr),
        .prog_data(prog_data), .external_fetch_pin(external_fetch_pin),
        .port_data(port_data), .sync(sync), .port_bus(port_bus), .host_wr(host_wr),
        .host_wdata(host_wdata), .host_rd(host_rd), .host_data_buffer(host_data_buffer),
        .host_status_register(host_status_register), .input_full_flag(input_full_flag),
        .output_full_flag(output_full_flag), .timer_overflow(timer_overflow),
        .reg_bank_sel(reg_bank_sel), .timer_overflow_irq(timer_overflow_irq),
        .acc(acc), .carry(carry));
    smx_prog_mem mem (.mclk(mclk), .prog_addr(prog_addr), .prog_data(prog_data));

    // 40 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // clocks since reset release, to find the middle of each machine cycle
    always @(posedge mclk)
    begin
        if (sys_rst)
            edges <= 0;
        else
            edges <= edges + 1;
    end

    // verdict and end of run
    task automatic final_report();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // compare one value with its expectation
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // go to mid machine cycle after k cycles have executed
    task automatic to_cycle(input int k);
        for (int i = 0; i < 400 && edges < 7 + 15 * k; i++)
            @(posedge mclk);
        #1;
        if (edges < 7 + 15 * k)
        begin
            n_fail++;
            final_report();
        end
    endtask : to_cycle
    // wait, bounded, for the cycle strobe to reach a level
    task automatic wait_sync(input logic lvl);
        for (int i = 0; i < 40 && sync !== lvl; i++)
        begin
            @(posedge mclk);
            #1;
        end
        if (sync !== lvl)
        begin
            n_fail++;
            final_report();
        end
    endtask : wait_sync
    // one-clock pulse on a host or timer line: 0 host write, 1 host read, 2 timer
    task automatic pulse(input int which);
        @(posedge mclk);
        host_wr <= (which == 0);
        host_rd <= (which == 1);
        timer_overflow <= (which == 2);
        @(posedge mclk);
        host_wr <= 1'b0;
        host_rd <= 1'b0;
        timer_overflow <= 1'b0;
        #1;
    endtask : pulse

    // main sequence
    initial
    begin
        n_fail = 0;
        checks = 0;
        sys_rst = 1'b1;
        external_fetch_pin = 1'b0;
        host_wr = 1'b0;
        host_rd = 1'b0;
        timer_overflow = 1'b0;
        reg_bank_sel = 1'b0;
        port_data = 8'h11;
        host_wdata = 8'h00;
        #1;
        foreach (image[i])
            mem.put(image[i][19:8], image[i][7:0]);
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        host_wdata <= 8'hA5;
        pulse(0);
        check({11'h000, input_full_flag}, 12'h001); // host write fills
        check({4'h0, host_status_register}, 12'h002); // input flag bit
        to_cycle(1);
        check({4'h0, acc}, 12'h0A5); // buffer read
        check({11'h000, input_full_flag}, 12'h000); // read clears flag
        check(port_bus, 12'h011); // port follows data with access off
        to_cycle(2);
        check({4'h0, host_status_register}, 12'h0A0); // upper nibble only
        to_cycle(3);
        check({4'h0, host_data_buffer}, 12'h0A5); // buffer written
        check({4'h0, host_status_register}, 12'h0A1); // output flag set
        pulse(1);
        check({11'h000, output_full_flag}, 12'h000); // host read clears
        $display("host buffer test done");
        to_cycle(4);
        check({3'h0, carry, acc}, 12'h14A); // bit 7 into carry
        to_cycle(5);
        check({3'h0, carry, acc}, 12'h095); // carry into bit 0
        to_cycle(7);
        check({4'h0, acc}, 12'h095); // store leaves acc
        to_cycle(8);
        check({4'h0, acc}, 12'h03C); // register swap
        to_cycle(9);
        check({4'h0, acc}, 12'h095); // memory swap
        to_cycle(10);
        check({4'h0, acc}, 12'h09C); // low nibble swap
        to_cycle(11);
        check({4'h0, acc}, 12'h035); // indirect load
        $display("data move test done");
        to_cycle(12);
        check({4'h0, acc}, 12'h035); // second cycle pending
        to_cycle(13);
        check({4'h0, acc}, 12'h05A); // current page byte
        check(prog_addr, 12'h00C); // one byte long
        to_cycle(15);
        check({4'h0, acc}, 12'h077); // page 3 byte
        check(prog_addr, 12'h00D); // one byte long
        check({11'h000, timer_overflow_irq}, 12'h000); // enable still off
        to_cycle(16);
        check({11'h000, timer_overflow_irq}, 12'h001); // enable set
        pulse(2);
        to_cycle(18);
        check(prog_addr, 12'h020); // taken on flag
        to_cycle(20);
        check(prog_addr, 12'h022); // flag was cleared
        $display("lookup and branch test done");
        @(posedge mclk);
        external_fetch_pin <= 1'b1;
        port_data <= 8'hC3;
        to_cycle(22);
        wait_sync(1'b0);
        wait_sync(1'b1);
        repeat (2) @(posedge mclk);
        #1;
        check(port_bus, 12'h0C3); // port data at rise
        @(posedge mclk);
        port_data <= 8'h3C;
        repeat (2) @(posedge mclk);
        #1;
        check(port_bus, 12'h0C3); // held until strobe fall
        wait_sync(1'b0);
        repeat (2) @(posedge mclk);
        #1;
        // three no-operations since the branch left the counter at 0x022
        check(port_bus, 12'h025); // counter at fall
        $display("external access test done");
        @(posedge mclk);
        reg_bank_sel <= 1'b1;
        to_cycle(26);
        check({4'h0, acc}, 12'h000); // bank one register starts clear
        to_cycle(27);
        check({4'h0, acc}, 12'h077); // bank one register kept acc
        $display("register bank test done");
        final_report();
    end
endmodule : tb_slave_mcu_instruction_exec
